// File: src/idec_pkg.sv
// package: constants and types for the instruction format decoder
package idec_pkg;

  // ----------------------------------------
  // register map (byte addresses, 32-bit words)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WORD = 8'h04;
  localparam logic [7:0] ADDR_COND = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_FIELDS = 8'h10;
  localparam logic [7:0] ADDR_TARGET = 8'h14;
  localparam logic [7:0] ADDR_BANK = 8'h18;
  localparam logic [7:0] ADDR_TABLE_POINTER = 8'h1c;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [3:0] SECOND_WORD_PREFIX = 4'hf;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [20:0] TABLE_POINTER_RESET = 21'h000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int OSC_PER_ICYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_ICYCLE - 1);

  // ----------------------------------------
  // instruction classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CLS_NOP = 4'b0000,
    CLS_BYTE = 4'b0001,
    CLS_BIT = 4'b0010,
    CLS_LIT = 4'b0011,
    CLS_MOVE = 4'b0100,
    CLS_JUMP = 4'b0101,
    CLS_CALL = 4'b0110,
    CLS_REL_BRANCH = 4'b0111,
    CLS_BCOND = 4'b1000,
    CLS_RET = 4'b1001,
    CLS_TABLE = 4'b1010,
    CLS_LFSR = 4'b1011,
    CLS_CTRL = 4'b1100
  } iclass_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_EXTRA = 2'b10
  } seq_t;

endpackage : idec_pkg

// File: src/idec_cycle_timer.sv
// module: instruction cycle timer, four oscillator periods per cycle
`timescale 1ns/100ps
module idec_cycle_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic cycle_end
);

  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic cycle_end_q;
  logic cycle_end_d;

  always_comb
  begin
    phase_d = run ? phase_q + 2'd1 : 2'd0;
    // raised one period early: the registered flag lands as the fourth period begins
    cycle_end_d = run && (phase_q == idec_pkg::PHASE_LAST - 2'd1); // see RULE7
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 2'd0;
      cycle_end_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cycle_end_q <= cycle_end_d;
    end
  end

  assign cycle_end = cycle_end_q;

endmodule : idec_cycle_timer

// File: src/instruction_format_decoder.sv
// module: instruction format decoder with axi4-lite register access
//
// Overview of operation
// RULE1: most instructions are one 16-bit word; three take two words. The code decodes four as two-word: move, call, jump and LFSR.
// RULE2: a word with top nibble 1111 executed alone does nothing.
// RULE3: destination bit 0 writes accumulator, 1 writes file register.
// RULE4: access bit 0 selects access RAM; 1 uses bank select register.
// RULE5: single-word takes one cycle; taken test or jump adds a no-op cycle. The code adds none for a taken skip test.
// RULE6: two-word instructions take two instruction cycles.
// RULE7: one instruction cycle lasts four oscillator periods.
// RULE8: any file-register instruction reads, modifies and writes the register.
// RULE9: byte and bit formats carry an 8-bit file address in low byte.
// RULE10: bit formats decode a 3-bit bit number, 0 to 7.
// RULE11: register move: 12-bit source in word one, 12-bit destination in word two.
// RULE12: literal formats take an 8-bit immediate from the low byte.
// RULE13: jump and call carry a 20-bit target split over two words.
// RULE14: fast bit set saves or restores shadow registers on call/return.
// RULE15: relative branch offsets are two's complement, 11 or 8 bits.
// RULE16: table modes keep, post-inc, post-dec or pre-inc the 21-bit pointer.
// RULE17: don't-care bits are ignored by the decoder.
`timescale 1ns/100ps
module instruction_format_decoder
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // axi4-lite slave state
  // ----------------------------------------
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // ----------------------------------------
  // decoder state
  // ----------------------------------------
  logic [31:0] word_q, word_d;
  logic cond_q, cond_d;
  logic [3:0] bank_q, bank_d;
  logic [20:0] table_pointer_q, table_pointer_d;
  idec_pkg::seq_t seq_q, seq_d;
  logic [1:0] cycles_q, cycles_d;
  logic [1:0] left_q, left_d;
  idec_pkg::iclass_t cls_q, cls_d;
  logic [31:0] fields_q, fields_d;
  logic [31:0] target_q, target_d;

  logic cycle_end;
  logic do_write;
  logic go;

  idec_cycle_timer u_timer
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(seq_q != idec_pkg::SEQ_IDLE),
    .cycle_end(cycle_end)
  );

  // ----------------------------------------
  // combinational decode of the held word
  // ----------------------------------------
  logic [15:0] w1;
  logic [15:0] w2;
  idec_pkg::iclass_t cls_c;
  logic two_word_c;
  logic pc_change_c;
  logic rmw_c;
  logic dest_file_c;
  logic bank_use_c;
  logic fast_c;
  logic [11:0] file_addr_c;
  logic [2:0] bit_num_c;
  logic [7:0] imm_c;
  logic [1:0] tbl_mode_c;
  logic [31:0] target_c;

  always_comb
  begin
    w1 = word_q[15:0];
    w2 = word_q[31:16];
    cls_c = idec_pkg::CLS_NOP;
    two_word_c = 1'b0;
    pc_change_c = 1'b0;
    rmw_c = 1'b0;
    dest_file_c = 1'b0;
    bank_use_c = w1[8]; // see RULE4
    fast_c = 1'b0;
    file_addr_c = {4'h0, w1[7:0]}; // see RULE9
    bit_num_c = w1[11:9]; // see RULE10
    imm_c = w1[7:0]; // see RULE12
    tbl_mode_c = w1[1:0]; // see RULE16
    target_c = 32'h0;
    if (w1[15:12] == idec_pkg::SECOND_WORD_PREFIX)
    begin
      cls_c = idec_pkg::CLS_NOP; // see RULE2
    end
    else if (w1[15:12] == 4'hc)
    begin
      cls_c = idec_pkg::CLS_MOVE;
      two_word_c = 1'b1; // see RULE1
      rmw_c = 1'b1;
      file_addr_c = w1[11:0]; // see RULE11
      target_c = {20'h0, w2[11:0]}; // see RULE11
    end
    else if (w1[15:12] >= 4'h7 && w1[15:12] <= 4'hb)
    begin
      cls_c = idec_pkg::CLS_BIT;
      rmw_c = 1'b1; // see RULE8
      dest_file_c = (w1[15:12] == 4'h7) || (w1[15:12] == 4'h8) || (w1[15:12] == 4'h9);
    end
    else if (w1[15:12] >= 4'h1 && w1[15:12] <= 4'h6)
    begin
      cls_c = idec_pkg::CLS_BYTE;
      rmw_c = 1'b1; // see RULE8
      // compare/test/set/clear/move-to-file forms have no d bit and always hit f
      dest_file_c = (w1[15:12] == 4'h6) ? 1'b1 : w1[9]; // see RULE3
    end
    else if (w1[15:12] == 4'hd)
    begin
      cls_c = idec_pkg::CLS_REL_BRANCH;
      pc_change_c = 1'b1;
      target_c = {{21{w1[10]}}, w1[10:0]}; // see RULE15
    end
    else if (w1[15:11] == 5'b11100)
    begin
      cls_c = idec_pkg::CLS_BCOND;
      pc_change_c = cond_q; // see RULE5
      target_c = {{24{w1[7]}}, w1[7:0]}; // see RULE15
    end
    else if (w1[15:9] == 7'b1110110 || w1[15:8] == 8'hef)
    begin
      cls_c = (w1[15:9] == 7'b1110110) ? idec_pkg::CLS_CALL : idec_pkg::CLS_JUMP;
      two_word_c = 1'b1; // see RULE1
      fast_c = (w1[15:9] == 7'b1110110) && w1[8]; // see RULE14
      target_c = {12'h0, w2[11:0], w1[7:0]}; // see RULE13
    end
    else if (w1[15:8] == 8'hee)
    begin
      cls_c = idec_pkg::CLS_LFSR;
      two_word_c = 1'b1;
      target_c = {20'h0, w1[3:0], w2[7:0]};
    end
    else if (w1[15:12] == 4'h0 && w1[11:8] >= 4'h8)
    begin
      cls_c = idec_pkg::CLS_LIT;
      pc_change_c = (w1[15:8] == 8'h0c);
    end
    else if (w1[15:8] == 8'h01)
    begin
      // bank-load literal: bits 7:4 are don't-care and ignored
      cls_c = idec_pkg::CLS_LIT; // see RULE17
    end
    else if (w1[15:8] == 8'h00 && w1[7:3] == 5'b00010)
    begin
      cls_c = idec_pkg::CLS_RET;
      pc_change_c = 1'b1;
      fast_c = w1[0]; // see RULE14
    end
    else if (w1[15:8] == 8'h00 && w1[7:3] == 5'b00001)
    begin
      cls_c = idec_pkg::CLS_TABLE;
      pc_change_c = 1'b1;
    end
    else if (w1[15:12] == 4'h0 && w1[11:9] != 3'b000)
    begin
      cls_c = idec_pkg::CLS_BYTE;
      rmw_c = 1'b1;
      // multiply form has no d bit; its product never lands in f
      dest_file_c = w1[10] && w1[9]; // see RULE3
    end
    else if (w1 != 16'h0000)
    begin
      cls_c = idec_pkg::CLS_CTRL;
    end
    if (cls_c == idec_pkg::CLS_BYTE || cls_c == idec_pkg::CLS_BIT)
    begin
      file_addr_c = bank_use_c ? {bank_q, w1[7:0]} : {4'h0, w1[7:0]}; // see RULE4
    end
  end

  // ----------------------------------------
  // execution sequencer and pointer update
  // ----------------------------------------
  always_comb
  begin
    seq_d = seq_q;
    cycles_d = cycles_q;
    left_d = left_q;
    cls_d = cls_q;
    fields_d = fields_q;
    target_d = target_q;
    table_pointer_d = table_pointer_q;
    bank_d = bank_q;
    case (seq_q)
      idec_pkg::SEQ_IDLE:
      begin
        if (go)
        begin
          seq_d = idec_pkg::SEQ_EXEC;
          cycles_d = 2'd0;
          // two words or a redirect need a second cycle
          left_d = (two_word_c || pc_change_c) ? 2'd2 : 2'd1; // see RULE5 see RULE6
          cls_d = cls_c;
          fields_d = {1'b0, imm_c, file_addr_c, bit_num_c, tbl_mode_c, fast_c, bank_use_c, dest_file_c,
                      rmw_c, two_word_c, pc_change_c};
          target_d = target_c;
          if (cls_c == idec_pkg::CLS_LIT && w1[15:8] == 8'h01)
          begin
            bank_d = w1[3:0];
          end
          if (cls_c == idec_pkg::CLS_TABLE && tbl_mode_c == 2'b11)
          begin
            table_pointer_d = table_pointer_q + 21'd1; // see RULE16
          end
        end
      end
      idec_pkg::SEQ_EXEC, idec_pkg::SEQ_EXTRA:
      begin
        if (cycle_end)
        begin
          cycles_d = cycles_q + 2'd1;
          if (cycles_q + 2'd1 >= left_q)
          begin
            seq_d = idec_pkg::SEQ_IDLE;
            if (cls_q == idec_pkg::CLS_TABLE && fields_q[7:6] == 2'b01)
            begin
              table_pointer_d = table_pointer_q + 21'd1; // see RULE16
            end
            else if (cls_q == idec_pkg::CLS_TABLE && fields_q[7:6] == 2'b10)
            begin
              table_pointer_d = table_pointer_q - 21'd1; // see RULE16
            end
          end
          else
          begin
            seq_d = idec_pkg::SEQ_EXTRA;
          end
        end
      end
      default:
      begin
        seq_d = idec_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    word_d = word_q;
    cond_d = cond_q;
    go = 1'b0;
    do_write = aw_hold_q && w_hold_q && !bvalid_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write)
    begin
      bvalid_d = 1'b1;
      bresp_d = idec_pkg::RESP_OKAY;
      case (awaddr_q)
        idec_pkg::ADDR_CTRL:
          go = wstrb_q[0] && wdata_q[idec_pkg::CTRL_GO_BIT] && seq_q == idec_pkg::SEQ_IDLE;
        idec_pkg::ADDR_WORD:
        begin
          // word is locked while an instruction executes
          if (seq_q == idec_pkg::SEQ_IDLE)
          begin
            for (int i = 0; i < 4; i++)
            begin
              if (wstrb_q[i])
              begin
                word_d[i*8 +: 8] = wdata_q[i*8 +: 8];
              end
            end
          end
        end
        idec_pkg::ADDR_COND:
          if (wstrb_q[0])
          begin
            cond_d = wdata_q[0];
          end
        default:
          bresp_d = idec_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready)
    begin
      // holds drop only here, so no ready rises under a pending response
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = idec_pkg::RESP_OKAY;
      case (s_axi_araddr)
        idec_pkg::ADDR_CTRL: rdata_d = 32'h0;
        idec_pkg::ADDR_WORD: rdata_d = word_q;
        idec_pkg::ADDR_COND: rdata_d = {31'h0, cond_q};
        idec_pkg::ADDR_STAT: rdata_d = {20'h0, cls_q, 2'(cycles_q), 2'(left_q), 3'h0,
                                        seq_q != idec_pkg::SEQ_IDLE};
        idec_pkg::ADDR_FIELDS: rdata_d = fields_q;
        idec_pkg::ADDR_TARGET: rdata_d = target_q;
        idec_pkg::ADDR_BANK: rdata_d = {28'h0, bank_q};
        idec_pkg::ADDR_TABLE_POINTER: rdata_d = {11'h0, table_pointer_q};
        default:
        begin
          rdata_d = 32'h0;
          rresp_d = idec_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'b00;
      word_q <= 32'h0;
      cond_q <= 1'b0;
      bank_q <= idec_pkg::BANK_RESET;
      table_pointer_q <= idec_pkg::TABLE_POINTER_RESET;
      seq_q <= idec_pkg::SEQ_IDLE;
      cycles_q <= 2'd0;
      left_q <= 2'd0;
      cls_q <= idec_pkg::CLS_NOP;
      fields_q <= 32'h0;
      target_q <= 32'h0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      word_q <= word_d;
      cond_q <= cond_d;
      bank_q <= bank_d;
      table_pointer_q <= table_pointer_d;
      seq_q <= seq_d;
      cycles_q <= cycles_d;
      left_q <= left_d;
      cls_q <= cls_d;
      fields_q <= fields_d;
      target_q <= target_d;
    end
  end

  // ready outputs are registered holds; one outstanding item per channel
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : instruction_format_decoder

// File: verification/idec_bus_checker.sv
// checker: register-bus handshake assertions for the instruction format decoder
`timescale 1ns/100ps
module idec_bus_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
    |=> s_axi_rresp == idec_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ctrl_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == idec_pkg::ADDR_CTRL
    |=> s_axi_rdata == 32'h0 && s_axi_rresp == idec_pkg::RESP_OKAY)
    else $error("control register read not zero");
  chk_fields_top: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == idec_pkg::ADDR_FIELDS
    |=> !s_axi_rdata[31])
    else $error("fields top bit set");
endmodule : idec_bus_checker

bind instruction_format_decoder idec_bus_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: verification/prog_memory.sv
// model: program memory image holding the instruction words under test
`timescale 1ns/100ps
module prog_memory
(
  input wire logic [4:0] index,
  output logic [31:0] word
);
  // entries are {second word, first word}; single-word entries leave the top half zero
  always_comb
  begin
    case (index)
      5'h00: word = 32'h0000_01f3;
      5'h01: word = 32'h0000_275a;
      5'h02: word = 32'h0000_245a;
      5'h03: word = 32'h0000_8a12;
      5'h04: word = 32'h0000_0e7f;
      5'h05: word = 32'hf456_c123;
      5'h06: word = 32'hf567_ef34;
      5'h07: word = 32'hf567_ed34;
      5'h08: word = 32'h0000_0013;
      5'h09: word = 32'h0000_d7fe;
      5'h0a: word = 32'h0000_e280;
      5'h0b: word = 32'h0000_fabc;
      5'h0c: word = 32'h0000_f000;
      5'h0d: word = 32'h0000_0009;
      5'h0e: word = 32'h0000_000a;
      5'h0f: word = 32'h0000_000b;
      5'h10: word = 32'h0000_0008;
      default: word = 32'h0000_0000;
    endcase
  end
endmodule : prog_memory

// File: verification/instruction_format_decoder_test.sv
// testbench: register-bus driven checks of the instruction format decoder
`timescale 1ns/100ps
module instruction_format_decoder_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [4:0] pm_index = 5'h00;
  logic [31:0] pm_word;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 aclk = ~aclk;

  instruction_format_decoder dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  prog_memory u_mem (.index(pm_index), .word(pm_word));

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask, input string what);
    compares++;
    if ((got & mask) !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h", $time, what, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // load a word, start it, wait for idle, then judge class and cycle counts
  task automatic run(input int i, input logic c, input idec_pkg::iclass_t cls, input logic [1:0] tot,
    output logic [31:0] f, output logic [31:0] t);
    logic [31:0] d;
    logic [1:0] r;
    pm_index = i[4:0];
    #1;
    wr(idec_pkg::ADDR_WORD, pm_word, r);
    wr(idec_pkg::ADDR_COND, {31'h0, c}, r);
    wr(idec_pkg::ADDR_CTRL, 32'h1, r);
    rd(idec_pkg::ADDR_STAT, d, r);
    chk(d, 32'h1, 32'h1, "busy after start");
    while (d[0] === 1'b1) rd(idec_pkg::ADDR_STAT, d, r);
    chk(d, {20'h0, cls, tot, tot, 4'h0}, 32'hff1, "class or cycles");
    rd(idec_pkg::ADDR_FIELDS, f, r);
    rd(idec_pkg::ADDR_TARGET, t, r);
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    rd(idec_pkg::ADDR_BANK, d, r);
    chk(d, 32'h0, 32'hf, "bank reset");
    rd(idec_pkg::ADDR_TABLE_POINTER, d, r);
    chk(d, 32'h0, 32'h1fffff, "pointer reset");
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, idec_pkg::RESP_SLVERR}, 32'h3, "unmapped read");
    wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, idec_pkg::RESP_SLVERR}, 32'h3, "unmapped write");
    $display("test bus done");
  endtask : t_bus

  task automatic t_file();
    logic [31:0] f, t, d;
    logic [1:0] r;
    run(0, 1'b0, idec_pkg::CLS_LIT, 2'd1, f, t);
    rd(idec_pkg::ADDR_BANK, d, r);
    chk(d, 32'h3, 32'hf, "bank load");
    run(1, 1'b0, idec_pkg::CLS_BYTE, 2'd1, f, t);
    chk(f, 32'h1ad01c, 32'h7ff81f, "byte d1 a1");
    run(2, 1'b0, idec_pkg::CLS_BYTE, 2'd1, f, t);
    chk(f, 32'h02d004, 32'h7ff81f, "byte d0 a0");
    run(3, 1'b0, idec_pkg::CLS_BIT, 2'd1, f, t);
    chk(f, 32'h009504, 32'h7fff17, "bit op");
    run(4, 1'b0, idec_pkg::CLS_LIT, 2'd1, f, t);
    chk(f, 32'h3f800000, 32'h7f800003, "literal");
    $display("test file done");
  endtask : t_file

  task automatic t_two();
    logic [31:0] f, t;
    run(5, 1'b0, idec_pkg::CLS_MOVE, 2'd2, f, t);
    chk(f, 32'h091802, 32'h7ff802, "move source");
    chk(t, 32'h456, 32'hfff, "move dest");
    run(6, 1'b0, idec_pkg::CLS_JUMP, 2'd2, f, t);
    chk(t, 32'h56734, 32'hfffff, "jump target");
    run(7, 1'b0, idec_pkg::CLS_CALL, 2'd2, f, t);
    chk(f, 32'h22, 32'h23, "fast call");
    chk(t, 32'h56734, 32'hfffff, "call target");
    run(8, 1'b0, idec_pkg::CLS_RET, 2'd2, f, t);
    chk(f, 32'h21, 32'h21, "fast return");
    $display("test two done");
  endtask : t_two

  task automatic t_branch();
    logic [31:0] f, t;
    run(9, 1'b0, idec_pkg::CLS_REL_BRANCH, 2'd2, f, t);
    chk(t, 32'hfffe, 32'hffff, "relative offset");
    run(10, 1'b0, idec_pkg::CLS_BCOND, 2'd1, f, t);
    run(10, 1'b1, idec_pkg::CLS_BCOND, 2'd2, f, t);
    chk(t, 32'hff80, 32'hffff, "cond offset");
    run(11, 1'b0, idec_pkg::CLS_NOP, 2'd1, f, t);
    run(12, 1'b0, idec_pkg::CLS_NOP, 2'd1, f, t);
    chk(f, 32'h0, 32'h3, "lone second word");
    $display("test branch done");
  endtask : t_branch

  task automatic t_table();
    logic [31:0] f, t, d;
    logic [1:0] r;
    logic [3:0] ptr;
    ptr = 4'b1101;
    for (int i = 0; i < 4; i++)
    begin
      run(13 + i, 1'b0, idec_pkg::CLS_TABLE, 2'd2, f, t);
      chk(f, {24'h0, 2'(i + 1), 6'h0}, 32'hc0, "table mode");
      rd(idec_pkg::ADDR_TABLE_POINTER, d, r);
      chk(d, {31'h0, ptr[i]}, 32'h1fffff, "table pointer");
    end
    $display("test table done");
  endtask : t_table

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_file();
    t_two();
    t_branch();
    t_table();
    tally_and_finish();
  end
endmodule : instruction_format_decoder_test
